// >>> hw/analog_channel_path.sv
`timescale 1ns/1ps

module analog_channel_path
    import analog_input_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    // sample and settings
    input wire analog_input_pkg::word_t sample,
    input wire logic sampleValid,
    input wire logic [2:0] filterShift,
    input wire analog_input_pkg::word_t alignOffset,
    input wire logic forceOn,
    input wire analog_input_pkg::word_t forceValue,
    input wire logic inUse,
    // result
    output analog_input_pkg::word_t value
);
    import analog_input_pkg::*;

    pathState_t st_ff;
    pathState_t nxt_st;
    logic signed [16:0] diff;

    always_comb begin
        nxt_st = st_ff;
        diff = $signed({sample[15], sample}) - $signed({st_ff.acc[15], st_ff.acc});
        if (sampleValid) begin
            // first-order smoothing, heavier with a larger shift
            if (filterShift == 3'h0) begin
                nxt_st.acc = sample;
            end else begin
                nxt_st.acc = st_ff.acc + 16'(diff >>> filterShift);
            end
        end
        if (!inUse) begin
            nxt_st.value = WORD_RESET;
        end else if (forceOn) begin
            nxt_st.value = forceValue;
        end else begin
            // wraps on overflow; software keeps offset within range
            nxt_st.value = st_ff.acc + alignOffset;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (clockEnable) begin
            st_ff <= nxt_st;
        end
    end

    assign value = st_ff.value;

endmodule

// >>> hw/analog_input_channel_objects.sv
`timescale 1ns/1ps

// Functional notes
// - measurement is read-only signed word
// - per-channel read-only error bit
// - bits 5/6 flag lower/upper tolerance area
// - bit 8 offset, bit 10 reference, 11 unused
// - bit 12 flags serial link failure
// - progress bits 0..2 while exchange runs
// - report bits 0..2 flag failed exchange
// - report bit 15 flags reconfiguration failure
// - fault word A bits 0,1,2
// - fault A bit 4 inoperative, 5 mismatch
// - fault A bit 6 link, 7 application
// - fault B bits 0,2,3,4
// - fault B bit 5 link or supply
// - fault B bit 6 underflow or recalibrated
// - fault B bit 7 overflow or aligned
// - force bit plus value substitutes measurement
// - clearing force bit restores measurement
// - forcing value word read/write
// - filter coefficient word read/write
// - alignment offset added, aligned flag set
// - threshold words reserved, no access
// - filter coefficient accepts 0 to 6
// - unused channel reads zero, flags inactive
module analog_input_channel_objects
    import analog_input_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    // front-end conditions
    input wire analog_input_pkg::cond_t [analog_input_pkg::CHANNELS-1:0] cond,
    input wire logic [analog_input_pkg::CHANNELS-1:0] inUse,
    input wire logic [analog_input_pkg::CHANNELS-1:0] reconfigureFail,
    // implicit input words
    input wire logic [analog_input_pkg::CH_W-1:0] inChan,
    input wire logic inIndex,
    output analog_input_pkg::word_t inData,
    output logic [analog_input_pkg::CHANNELS-1:0] channelFaultFlag,
    // explicit exchanges
    input wire analog_input_pkg::xchReq_t xchReq,
    output logic xchReady,
    output analog_input_pkg::xchAns_t xchAns
);
    import analog_input_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        chanRegs_t [CHANNELS-1:0] ch;
        xchState_t xs;
        xchReq_t cur;
        logic [2:0] cnt;
        logic curErr;
        word_t inData;
        logic [CHANNELS-1:0] chErr;
        logic ready;
        xchAns_t ans;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    word_t [CHANNELS-1:0] pathValue;
    word_t [CHANNELS-1:0] measFlags;
    word_t [CHANNELS-1:0] faultA;
    word_t [CHANNELS-1:0] faultB;
    word_t [CHANNELS-1:0] progress;
    word_t [CHANNELS-1:0] report;

    // ****************************************
    // decoding used for every channel
    // ****************************************
    function automatic logic aligned(chanRegs_t r);
        aligned = (r.alignOffset != WORD_RESET);
    endfunction

    function automatic word_t reportWord(chanRegs_t r);
        reportWord = WORD_RESET;
        reportWord[2:0] = r.report[2:0];
        reportWord[RPT_RECONFIG] = r.report[3];
    endfunction

    // index legal for an exchange kind; reserved words never are
    function automatic logic indexOk(xchKind_t k, logic [3:0] i, logic wr);
        indexOk = 1'b0;
        if (i == IDX_THRESH_A || i == IDX_THRESH_B) begin
            indexOk = 1'b0;
        end else if (k == XCH_STATUS) begin
            indexOk = !wr && (i <= IDX_FAULT_B);
        end else if (k == XCH_COMMAND) begin
            indexOk = (i == IDX_COMMAND) || (i == IDX_FORCE_VAL);
        end else if (k == XCH_ADJUST) begin
            indexOk = (i == IDX_FILTER) || (i == IDX_ALIGN);
        end
    endfunction

    // ****************************************
    // per-channel paths and status words
    // ****************************************
    for (genvar c = 0; c < CHANNELS; c++) begin : gChan
        analog_channel_path uPath (
            .clock(clock),
            .rst_n(rst_n),
            .clockEnable(clockEnable),
            .sample(cond[c].rawSample),
            .sampleValid(cond[c].sampleValid),
            .filterShift(st_ff.ch[c].filterCoef[2:0]),
            .alignOffset(st_ff.ch[c].alignOffset),
            .forceOn(st_ff.ch[c].forceOn),
            .forceValue(st_ff.ch[c].forceValue),
            .inUse(inUse[c]),
            .value(pathValue[c])
        );

        always_comb begin
            measFlags[c] = WORD_RESET;
            faultA[c] = WORD_RESET;
            faultB[c] = WORD_RESET;
            // unused channel keeps measurement flags and both fault words quiet
            if (inUse[c]) begin
                measFlags[c][MF_ALIGNED] = aligned(st_ff.ch[c]);
                measFlags[c][MF_FORCED] = st_ff.ch[c].forceOn;
                measFlags[c][MF_LOW_TOL] = cond[c].lowTol;
                measFlags[c][MF_HIGH_TOL] = cond[c].highTol;
                measFlags[c][MF_OFFSET_ERR] = cond[c].offsetErr;
                measFlags[c][MF_REF_ERR] = cond[c].refErr;
                measFlags[c][MF_SUPPLY_UNUSED] = 1'b0;
                measFlags[c][MF_SERIAL_LINK] = cond[c].serialLinkFault;
                faultA[c][FA_SENSOR] = cond[c].sensorFault;
                faultA[c][FA_RANGE] = cond[c].belowRange | cond[c].aboveRange;
                faultA[c][FA_INOPERATIVE] = cond[c].inoperative;
                faultA[c][FA_CONFIG] = cond[c].configMismatch;
                faultA[c][FA_LINK] = cond[c].controllerLinkFault;
                faultA[c][FA_APPLICATION] = st_ff.ch[c].appFault;
                faultB[c][FB_NOT_READY] = cond[c].notReady;
                faultB[c][FB_CALIB] = cond[c].calibrationFault;
                faultB[c][FB_CAL_ZERO] = cond[c].calZeroFault;
                faultB[c][FB_CAL_REF] = cond[c].calReferenceFault;
                faultB[c][FB_LINK_SUPPLY] = cond[c].serialLinkFault
                    | cond[c].supplyFault;
                faultB[c][FB_BELOW] = cond[c].belowRange | cond[c].recalibrated;
                faultB[c][FB_ABOVE] = cond[c].aboveRange | aligned(st_ff.ch[c]);
                // summary of the hard faults in both words
                faultA[c][FA_REPORT] = (|faultA[c]) | (|faultB[c][5:0]);
            end
            progress[c] = WORD_RESET;
            if (st_ff.xs != XS_IDLE && st_ff.cur.chan == CH_W'(c)) begin
                progress[c][st_ff.cur.kind] = 1'b1;
            end
            report[c] = reportWord(st_ff.ch[c]);
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ans.done = 1'b0;
        nxt_st.ans.fail = 1'b0;

        // implicit words refreshed every cycle
        if (inIndex == IDX_MEASURE) begin
            nxt_st.inData = pathValue[inChan];
        end else begin
            nxt_st.inData = measFlags[inChan];
        end
        for (int c = 0; c < CHANNELS; c++) begin
            // bits 6/7 of word B may mean recalibrated or aligned, so left out
            nxt_st.chErr[c] = (|faultA[c]) | (|faultB[c][5:0]);
        end

        case (st_ff.xs)
            XS_IDLE: begin
                // one exchange at a time; caller waits for xchReady first
                if (xchReq.valid) begin
                    nxt_st.cur = xchReq;
                    nxt_st.curErr = !indexOk(xchReq.kind, xchReq.index, xchReq.write);
                    nxt_st.cnt = EXCH_CYCLES;
                    nxt_st.xs = XS_RUN;
                    nxt_st.ready = 1'b0;
                    // a new exchange clears the old report of its kind
                    nxt_st.ch[xchReq.chan].report[xchReq.kind] = 1'b0;
                end
            end
            XS_RUN: begin
                nxt_st.cnt = st_ff.cnt - 3'h1;
                if (st_ff.cnt == 3'h1) begin
                    nxt_st.xs = XS_DONE;
                end
            end
            XS_DONE: begin
                nxt_st.xs = XS_IDLE;
                nxt_st.ready = 1'b1;
                nxt_st.ans.done = 1'b1;
                nxt_st.ans.fail = st_ff.curErr;
                nxt_st.ans.rdata = WORD_RESET;
                if (st_ff.curErr) begin
                    nxt_st.ch[st_ff.cur.chan].report[st_ff.cur.kind] = 1'b1;
                end else if (st_ff.cur.write) begin
                    if (st_ff.cur.index == IDX_COMMAND) begin
                        // set to force, clear to return to live data
                        nxt_st.ch[st_ff.cur.chan].forceOn =
                            st_ff.cur.wdata[CMD_FORCE_BIT];
                    end else if (st_ff.cur.index == IDX_FORCE_VAL) begin
                        nxt_st.ch[st_ff.cur.chan].forceValue = st_ff.cur.wdata;
                    end else if (st_ff.cur.index == IDX_FILTER) begin
                        if (st_ff.cur.wdata <= FILTER_MAX) begin
                            nxt_st.ch[st_ff.cur.chan].filterCoef = st_ff.cur.wdata;
                            nxt_st.ch[st_ff.cur.chan].appFault = 1'b0;
                        end else begin
                            // out-of-range coefficient is refused, old one kept
                            nxt_st.ch[st_ff.cur.chan].appFault = 1'b1;
                            nxt_st.ch[st_ff.cur.chan].report[XCH_ADJUST] = 1'b1;
                            nxt_st.ans.fail = 1'b1;
                        end
                    end else if (st_ff.cur.index == IDX_ALIGN) begin
                        nxt_st.ch[st_ff.cur.chan].alignOffset = st_ff.cur.wdata;
                    end
                end else begin
                    if (st_ff.cur.index == IDX_PROGRESS) begin
                        nxt_st.ans.rdata = progress[st_ff.cur.chan];
                    end else if (st_ff.cur.index == IDX_REPORT) begin
                        nxt_st.ans.rdata = report[st_ff.cur.chan];
                    end else if (st_ff.cur.index == IDX_FAULT_A) begin
                        nxt_st.ans.rdata = faultA[st_ff.cur.chan];
                    end else if (st_ff.cur.index == IDX_FAULT_B) begin
                        nxt_st.ans.rdata = faultB[st_ff.cur.chan];
                    end else if (st_ff.cur.index == IDX_COMMAND) begin
                        nxt_st.ans.rdata[CMD_FORCE_BIT] = st_ff.ch[st_ff.cur.chan].forceOn;
                    end else if (st_ff.cur.index == IDX_FORCE_VAL) begin
                        nxt_st.ans.rdata = st_ff.ch[st_ff.cur.chan].forceValue;
                    end else if (st_ff.cur.index == IDX_FILTER) begin
                        nxt_st.ans.rdata = st_ff.ch[st_ff.cur.chan].filterCoef;
                    end else if (st_ff.cur.index == IDX_ALIGN) begin
                        nxt_st.ans.rdata = st_ff.ch[st_ff.cur.chan].alignOffset;
                    end
                end
            end
            default: begin
                nxt_st.xs = XS_IDLE;
            end
        endcase

        // reconfiguration failure set here; the clear below skips a failing channel, so it beats any clear
        for (int c = 0; c < CHANNELS; c++) begin
            if (reconfigureFail[c]) begin
                nxt_st.ch[c].report[3] = 1'b1;
            end
        end
        // a new adjustment exchange starts with a clean reconfig flag
        if (st_ff.xs == XS_IDLE && xchReq.valid && xchReq.kind == XCH_ADJUST
            && !reconfigureFail[xchReq.chan]) begin
            nxt_st.ch[xchReq.chan].report[3] = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.ready <= 1'b1;
        end else if (clockEnable) begin
            st_ff <= nxt_st;
        end
    end

    assign inData = st_ff.inData;
    assign channelFaultFlag = st_ff.chErr;
    assign xchReady = st_ff.ready;
    assign xchAns = st_ff.ans;

endmodule

// >>> include/analog_input_pkg.sv
package analog_input_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int CHANNELS = 4;
    localparam int CH_W = 2;
    typedef logic [15:0] word_t;

    // ****************************************
    // word indices: input space (measurement side)
    // ****************************************
    localparam logic IDX_MEASURE = 1'b0;
    localparam logic IDX_MEAS_FLAGS = 1'b1;

    // ****************************************
    // word indices: exchange space
    // ****************************************
    localparam logic [3:0] IDX_PROGRESS = 4'h0;
    localparam logic [3:0] IDX_REPORT = 4'h1;
    localparam logic [3:0] IDX_FAULT_A = 4'h2;
    localparam logic [3:0] IDX_FAULT_B = 4'h3;
    localparam logic [3:0] IDX_COMMAND = 4'h4;
    localparam logic [3:0] IDX_FORCE_VAL = 4'h5;
    localparam logic [3:0] IDX_FILTER = 4'h8;
    localparam logic [3:0] IDX_ALIGN = 4'h9;
    localparam logic [3:0] IDX_THRESH_A = 4'ha;
    localparam logic [3:0] IDX_THRESH_B = 4'hb;

    // ****************************************
    // field positions
    // ****************************************
    localparam int MF_ALIGNED = 0;
    localparam int MF_FORCED = 1;
    localparam int MF_LOW_TOL = 5;
    localparam int MF_HIGH_TOL = 6;
    localparam int MF_OFFSET_ERR = 8;
    localparam int MF_REF_ERR = 10;
    localparam int MF_SUPPLY_UNUSED = 11;
    localparam int MF_SERIAL_LINK = 12;
    localparam int RPT_RECONFIG = 15;
    localparam int CMD_FORCE_BIT = 13;
    localparam int FA_SENSOR = 0;
    localparam int FA_RANGE = 1;
    localparam int FA_REPORT = 2;
    localparam int FA_INOPERATIVE = 4;
    localparam int FA_CONFIG = 5;
    localparam int FA_LINK = 6;
    localparam int FA_APPLICATION = 7;
    localparam int FB_NOT_READY = 0;
    localparam int FB_CALIB = 2;
    localparam int FB_CAL_ZERO = 3;
    localparam int FB_CAL_REF = 4;
    localparam int FB_LINK_SUPPLY = 5;
    localparam int FB_BELOW = 6;
    localparam int FB_ABOVE = 7;

    // ****************************************
    // values and counts
    // ****************************************
    localparam logic [15:0] FILTER_MAX = 16'h0006;
    localparam word_t WORD_RESET = 16'h0000;
    localparam logic [2:0] EXCH_CYCLES = 3'h4;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {XCH_STATUS, XCH_COMMAND, XCH_ADJUST} xchKind_t;
    typedef enum logic [1:0] {XS_IDLE, XS_RUN, XS_DONE} xchState_t;

    typedef struct packed {
        word_t rawSample;
        logic sampleValid;
        logic lowTol;
        logic highTol;
        logic offsetErr;
        logic refErr;
        logic serialLinkFault;
        logic sensorFault;
        logic belowRange;
        logic aboveRange;
        logic inoperative;
        logic configMismatch;
        logic controllerLinkFault;
        logic notReady;
        logic calibrationFault;
        logic calZeroFault;
        logic calReferenceFault;
        logic supplyFault;
        logic recalibrated;
    } cond_t;

    typedef struct packed {
        logic valid;
        xchKind_t kind;
        logic [CH_W-1:0] chan;
        logic [3:0] index;
        logic write;
        word_t wdata;
    } xchReq_t;

    typedef struct packed {
        logic done;
        logic fail;
        word_t rdata;
    } xchAns_t;

    typedef struct packed {
        logic forceOn;
        word_t forceValue;
        word_t filterCoef;
        word_t alignOffset;
        logic [3:0] report;
        logic appFault;
    } chanRegs_t;

    typedef struct packed {
        word_t acc;
        word_t value;
    } pathState_t;

endpackage

// >>> verif/analog_input_channel_properties.sv
`timescale 1ns/1ps

module analog_input_channel_properties
    import analog_input_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    // inputs
    input wire analog_input_pkg::cond_t [analog_input_pkg::CHANNELS-1:0] cond,
    input wire logic [analog_input_pkg::CHANNELS-1:0] inUse,
    input wire logic [analog_input_pkg::CH_W-1:0] inChan,
    input wire logic inIndex,
    input wire analog_input_pkg::xchReq_t xchReq,
    // outputs
    input wire analog_input_pkg::word_t inData,
    input wire logic [analog_input_pkg::CHANNELS-1:0] channelFaultFlag,
    input wire logic xchReady,
    input wire analog_input_pkg::xchAns_t xchAns
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic take = clockEnable && xchReady && xchReq.valid;
    wire logic rd = clockEnable && inIndex == IDX_MEAS_FLAGS && inUse[inChan];
    // recalibrated and aligned are not faults, so they stay out
    wire logic anyFault = cond[1].sensorFault | cond[1].belowRange | cond[1].aboveRange
        | cond[1].inoperative | cond[1].configMismatch | cond[1].controllerLinkFault
        | cond[1].notReady | cond[1].calibrationFault | cond[1].calZeroFault
        | cond[1].calReferenceFault | cond[1].serialLinkFault | cond[1].supplyFault;

    a_busy_hold: assert property (take |=> !xchReady [*5] ##1 (xchReady && xchAns.done))
        else $error("exchange busy window wrong");
    a_done_cause: assert property (xchAns.done |-> !$past(xchReady))
        else $error("done without exchange");
    a_done_pulse: assert property (xchAns.done |=> !xchAns.done)
        else $error("done longer than one cycle");
    a_fail_done: assert property (xchAns.fail |-> xchAns.done)
        else $error("fail without done");
    a_rdata_hold: assert property (!xchAns.done |-> $stable(xchAns.rdata))
        else $error("read data moved");
    a_tol_flags: assert property (rd |=> inData[6:5] == $past({cond[inChan].highTol,
        cond[inChan].lowTol}))
        else $error("tolerance flags wrong");
    a_err_flags: assert property (rd |=> inData[12:8] == {$past(cond[inChan].serialLinkFault),
        1'b0, $past(cond[inChan].refErr), 1'b0, $past(cond[inChan].offsetErr)})
        else $error("error flags wrong");
    a_unused_zero: assert property ((inChan == 2'h3 && !inUse[3]) [*3] |=> inData == 16'h0000)
        else $error("unused channel not zero");
    a_fault_flag: assert property (inUse[1] && anyFault |=> channelFaultFlag[1])
        else $error("fault flag missing");

    c_fail: cover property (xchAns.done && xchAns.fail);
    c_forced: cover property (rd ##1 inData[1]);
    c_fault: cover property (channelFaultFlag[1]);
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps

module tb;
    import analog_input_pkg::*;
    logic clock, rst_n, clockEnable, inIndex, peekOn, xchReady;
    cond_t [CHANNELS-1:0] cond;
    logic [CHANNELS-1:0] inUse, reconfigureFail, channelFaultFlag;
    logic [CH_W-1:0] inChan;
    word_t inData, r;
    xchReq_t xchReq;
    xchAns_t xchAns;
    word_t pq[$];
    logic [17:0] xq[$];
    logic [17:0] e;
    word_t rpt[CHANNELS];
    int failCount, compares, cycles;
    cond_t c;
    xchKind_t bk[5] = '{XCH_STATUS, XCH_COMMAND, XCH_ADJUST, XCH_ADJUST, XCH_COMMAND};
    logic [3:0] bi[5] = '{4'h4, 4'h8, IDX_THRESH_A, IDX_THRESH_B, IDX_THRESH_A};

    analog_input_channel_objects DUT (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
        .cond(cond), .inUse(inUse), .reconfigureFail(reconfigureFail), .inChan(inChan),
        .inIndex(inIndex), .inData(inData), .channelFaultFlag(channelFaultFlag),
        .xchReq(xchReq), .xchReady(xchReady), .xchAns(xchAns));
    xch_controller ctl (.clock(clock), .rst_n(rst_n), .xchReady(xchReady), .xchAns(xchAns),
        .xchReq(xchReq));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    task automatic check(word_t seen, word_t exp);
        compares++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic completeRun;
        if (failCount == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic sample(logic [1:0] ch, word_t v);
        tick;
        cond[ch].rawSample = v;
        cond[ch].sampleValid = 1'b1;
        tick;
        cond[ch].sampleValid = 1'b0;
    endtask
    task automatic peek(logic [1:0] ch, logic idx, word_t exp);
        tick;
        inChan = ch;
        inIndex = idx;
        tick;
        pq.push_back(exp);
        peekOn = 1'b1;
        tick;
        peekOn = 1'b0;
    endtask
    // report bits are modelled here: cleared on acceptance, set on failure
    task automatic xch(xchKind_t k, logic [1:0] ch, logic [3:0] idx, logic wr, word_t wd,
                       logic ef, word_t ed);
        rpt[ch][k] = 1'b0;
        if (k == XCH_ADJUST) rpt[ch][15] = 1'b0;
        if (k == XCH_STATUS && idx == IDX_REPORT) ed = rpt[ch];
        xq.push_back({!wr && !ef, ef, ed});
        ctl.run(k, ch, idx, wr, wd);
        rpt[ch][k] = ef;
        tick;
    endtask
    function automatic word_t fb(cond_t x, logic al);
        fb = {8'h0, x.aboveRange | al, x.belowRange | x.recalibrated,
              x.serialLinkFault | x.supplyFault, x.calReferenceFault, x.calZeroFault,
              x.calibrationFault, 1'b0, x.notReady};
    endfunction
    function automatic word_t fa(cond_t x, logic app);
        word_t b;
        b = fb(x, 1'b0);
        fa = {8'h0, app, x.controllerLinkFault, x.configMismatch, x.inoperative, 2'h0,
              x.belowRange | x.aboveRange, x.sensorFault};
        fa[2] = (|fa) | (|b[5:0]);
    endfunction
    function automatic word_t mf(cond_t x, logic al, logic fo);
        mf = {3'h0, x.serialLinkFault, 1'b0, x.refErr, 1'b0, x.offsetErr, 1'b0, x.highTol,
              x.lowTol, 3'h0, fo, al};
    endfunction

    // ****************************************
    // result monitor and timeout
    // ****************************************
    always @(posedge clock) begin
        if (peekOn === 1'b1) check(inData, pq.pop_front());
        if (xchAns.done === 1'b1) begin
            e = xq.pop_front();
            check({15'h0, xchAns.fail}, {15'h0, e[16]});
            if (e[17]) check(xchAns.rdata, e[15:0]);
        end
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            completeRun;
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        rst_n = 1'b0;
        clockEnable = 1'b1;
        cond = '0;
        inUse = '1;
        reconfigureFail = '0;
        inChan = '0;
        inIndex = 1'b0;
        peekOn = 1'b0;
        failCount = 0;
        compares = 0;
        cycles = 0;
        rpt = '{default: '0};
        void'($urandom(32'hcc682471));
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        check({15'h0, xchReady}, 16'h0001);
        peek(0, IDX_MEASURE, 16'h0000);
        xch(XCH_STATUS, 0, IDX_FAULT_A, 0, 0, 0, 16'h0000);
        xch(XCH_STATUS, 0, IDX_PROGRESS, 0, 0, 0, 16'h0001);
        xch(XCH_STATUS, 0, IDX_FAULT_B, 0, 0, 0, 16'h0000);
        r = 16'($urandom);
        sample(0, r);
        peek(0, IDX_MEASURE, r);
        xch(XCH_ADJUST, 0, IDX_ALIGN, 1, 16'd600, 0, 0);
        xch(XCH_ADJUST, 0, IDX_ALIGN, 0, 0, 0, 16'd600);
        sample(0, 16'd2400);
        peek(0, IDX_MEASURE, 16'd3000);
        peek(0, IDX_MEAS_FLAGS, 16'h0001);
        xch(XCH_STATUS, 0, IDX_FAULT_B, 0, 0, 0, 16'h0080);
        r = 16'($urandom);
        xch(XCH_COMMAND, 0, IDX_FORCE_VAL, 1, r, 0, 0);
        xch(XCH_COMMAND, 0, IDX_FORCE_VAL, 0, 0, 0, r);
        xch(XCH_COMMAND, 0, IDX_COMMAND, 1, 16'hffff, 0, 0);
        xch(XCH_COMMAND, 0, IDX_COMMAND, 0, 0, 0, 16'h2000);
        peek(0, IDX_MEASURE, r);
        peek(0, IDX_MEAS_FLAGS, 16'h0003);
        xch(XCH_COMMAND, 0, IDX_COMMAND, 1, 16'h0000, 0, 0);
        peek(0, IDX_MEASURE, 16'd3000);
        clockEnable = 1'b0;
        sample(0, 16'h1234);
        clockEnable = 1'b1;
        peek(0, IDX_MEASURE, 16'd3000);
        xch(XCH_ADJUST, 0, IDX_FILTER, 1, FILTER_MAX, 0, 0);
        xch(XCH_ADJUST, 0, IDX_FILTER, 1, FILTER_MAX + 16'h1, 1, 0);
        xch(XCH_ADJUST, 0, IDX_FILTER, 0, 0, 0, FILTER_MAX);
        xch(XCH_STATUS, 0, IDX_FAULT_A, 0, 0, 0, 16'h0084);
        check({15'h0, channelFaultFlag[0]}, 16'h0001);
        xch(XCH_ADJUST, 0, IDX_FILTER, 1, 16'h0000, 0, 0);
        for (int i = 0; i < 5; i++) begin
            xch(bk[i], 0, bi[i], 0, 0, 1, 0);
            xch(XCH_STATUS, 0, IDX_REPORT, 0, 0, 0, 0);
        end
        tick;
        reconfigureFail[2] = 1'b1;
        tick;
        reconfigureFail[2] = 1'b0;
        rpt[2][15] = 1'b1;
        xch(XCH_STATUS, 2, IDX_REPORT, 0, 0, 0, 0);
        xch(XCH_ADJUST, 2, IDX_ALIGN, 0, 0, 0, 16'h0000);
        xch(XCH_STATUS, 2, IDX_REPORT, 0, 0, 0, 0);
        for (int i = 0; i < 8; i++) begin
            c = {16'($urandom), 1'b0, 17'($urandom)};
            cond[1] = c;
            peek(1, IDX_MEAS_FLAGS, mf(c, 1'b0, 1'b0));
            xch(XCH_STATUS, 1, IDX_FAULT_A, 0, 0, 0, fa(c, 1'b0));
            xch(XCH_STATUS, 1, IDX_FAULT_B, 0, 0, 0, fb(c, 1'b0));
            r = fa(c, 1'b0);
            check({15'h0, channelFaultFlag[1]}, {15'h0, |r});
        end
        cond[3] = {16'h1234, 1'b1, 17'h1ffff};
        inUse[3] = 1'b0;
        peek(3, IDX_MEASURE, 16'h0000);
        peek(3, IDX_MEAS_FLAGS, 16'h0000);
        check(16'(xq.size() + pq.size()), 16'h0000);
        completeRun;
    end
endmodule

bind analog_input_channel_objects analog_input_channel_properties chk (.clock(clock),
    .rst_n(rst_n), .clockEnable(clockEnable), .cond(cond), .inUse(inUse), .inChan(inChan),
    .inIndex(inIndex), .xchReq(xchReq), .inData(inData), .channelFaultFlag(channelFaultFlag),
    .xchReady(xchReady), .xchAns(xchAns));

// >>> verif/xch_controller.sv
`timescale 1ns/1ps

module xch_controller
    import analog_input_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // exchange port
    input wire logic xchReady,
    input wire analog_input_pkg::xchAns_t xchAns,
    output analog_input_pkg::xchReq_t xchReq
);
    initial xchReq = '0;

    // called just after an edge; returns just after the done edge
    task automatic run(xchKind_t k, logic [1:0] ch, logic [3:0] idx, logic wr, word_t wd);
        int n;
        n = 0;
        repeat ($urandom_range(0, 2)) @(posedge clock);
        #1;
        while ((xchReady !== 1'b1 || rst_n !== 1'b1) && n < 50) begin
            @(posedge clock);
            #1;
            n++;
        end
        xchReq = '{1'b1, k, ch, idx, wr, wd};
        @(posedge clock);
        #1;
        // released index and data fields must not keep their last value
        xchReq.valid = 1'b0;
        xchReq.index = ~idx;
        xchReq.wdata = ~wd;
        n = 0;
        while (xchAns.done !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
endmodule
